// ### src/sinc_ctrl_pkg.sv
// Shared constants for the decimating filter control block and its host end.
// Assumes one 20 MHz clock and an active-low asynchronous reset everywhere.
package sinc_ctrl_pkg;
  // ==========================================================================
  // Device register map (device's own configuration port)
  localparam logic [7:0] PIN_FUNCTION_SELECT_B_OFFSET = 8'h1A;
  localparam logic [7:0] PIN_FUNCTION_SELECT_C_OFFSET = 8'h1B;
  localparam logic [7:0] FILTER_CONFIGURATION_OFFSET  = 8'h29;
  localparam logic [7:0] FILTER_CONFIGURATION_RESET   = 8'h00;
  localparam logic [7:0] PIN_FUNCTION_RESET           = 8'h00;
  // Filter configuration fields
  localparam int PATH_LSB = 0;
  localparam int DEC_LSB  = 4;
  // Pin function codes, low nibble = first pin, high nibble = second pin
  localparam logic [3:0] PIN_FN_READY = 4'h3;
  localparam logic [3:0] PIN_FN_SYNC  = 4'h4;
  localparam logic [3:0] DEC_MAX_SINC = 4'h9;
  localparam logic [3:0] DEC_MAX_COMP = 4'h7;
  // ==========================================================================
  // Paths
  typedef enum logic [1:0] {
    PATH_BYPASS = 2'h0,
    PATH_SINC1  = 2'h1,
    PATH_SINC5  = 2'h2,
    PATH_COMP   = 2'h3
  } path_e;
  // Settling terms: 2 + (k*D + c)
  localparam int SINC1_K = 1;
  localparam int SINC1_C = 1;
  localparam int SINC5_K = 5;
  localparam int SINC5_C = 4;
  localparam int COMP_K  = 35;
  localparam int COMP_C  = 10;
  localparam int SETTLE_BASE = 2;
  localparam int DATA_W = 20;
  localparam int CNT_W  = 16;
  // ==========================================================================
  // Host controller's own registers
  localparam logic [3:0] HOST_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] HOST_CFG_ADDR    = 4'h1;
  localparam logic [3:0] HOST_DATA_ADDR   = 4'h2;
  localparam logic [3:0] HOST_STATUS_ADDR = 4'h3;
  localparam logic [3:0] HOST_MASK_ADDR   = 4'h4;
  localparam logic [3:0] HOST_REPEAT_ADDR = 4'h5;
  localparam int ST_RESULT  = 0;
  localparam int ST_REPEAT  = 1;
  localparam int ST_SYNCED  = 2;
  localparam int HOST_ST_W  = 3;
  // Sync held over this many convert strobes (one full conversion minimum)
  localparam int SYNC_HOLD_STROBES = 2;
endpackage

// ### src/sinc_link_if.sv
// Pin-level link between the converter's filter control and its host.
// Assumes both ends share clk_in; the bench joins the two modports.
`timescale 1ns/100ps
interface sinc_link_if;
  import sinc_ctrl_pkg::*;
  logic              convert_strobe;
  logic              cfg_wr;
  logic [7:0]        cfg_addr;
  logic [7:0]        cfg_wdata;
  logic [1:0]        pin_from_host;
  logic [1:0]        pin_to_host;
  logic [1:0]        pin_oe;
  logic [DATA_W-1:0] sample;
  logic [DATA_W-1:0] lvds_word;
  logic              lvds_frame;
  modport device (
    input  convert_strobe, cfg_wr, cfg_addr, cfg_wdata, pin_from_host, sample,
    output pin_to_host, pin_oe, lvds_word, lvds_frame
  );
  modport host (
    output convert_strobe, cfg_wr, cfg_addr, cfg_wdata, pin_from_host,
    input  pin_to_host, pin_oe, lvds_word, lvds_frame
  );
endinterface

// ### src/sinc_filter_ctrl.sv
// Device end: filter path select, decimation, sync reset, ready pin, output hold.
// Assumes the host steps conversions with convert_strobe and writes config by port.
//
// Operation
// - Path chosen by two configuration bits
// - Path 00 bypasses, default selection
// - Path 01 first-order, ratio 2..1024
// - Path 10 fifth-order, ratio 2..256
// - Path 11 compensated, ratio 4..512
// - Four-bit code sets power-of-two ratio
// - Any filter configuration write resets filter
// - Low sync pin resets and realigns
// - Host syncs before every FIFO record; no FIFO here, host syncs on control bit 1
// - Function 0011 drives active-low ready
// - Ready selectable in either pin register
// - Output holds previous result, repeats
// - Host keeps clock, rereads or discards
// - Streaming only on the LVDS link
// - Host times reads from ready pin
// - First output waits settling strobe count
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module sinc_filter_ctrl
  import sinc_ctrl_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  sinc_link_if.device            link,
  output logic [7:0]             filter_configuration_out,
  output logic                   settled_out
);
  // ==========================================================================
  // Decoding
  function automatic logic [CNT_W-1:0] ratio_of(input logic [1:0] p, input logic [3:0] c);
    logic [CNT_W-1:0] r;
    r = '0;
    unique case (p)
      PATH_BYPASS: r = CNT_W'(1);
      PATH_COMP:   r = CNT_W'(4) << c;
      default:     r = CNT_W'(2) << c;
    endcase
    return r;
  endfunction

  function automatic logic [CNT_W-1:0] settle_of(input logic [1:0] p,
                                                input logic [CNT_W-1:0] d);
    logic [CNT_W-1:0] s;
    s = '0;
    unique case (p)
      PATH_SINC1: s = CNT_W'(SETTLE_BASE + SINC1_C) + CNT_W'(SINC1_K) * d;
      PATH_SINC5: s = CNT_W'(SETTLE_BASE + SINC5_C) + CNT_W'(SINC5_K) * d;
      PATH_COMP:  s = CNT_W'(SETTLE_BASE + COMP_C) + CNT_W'(COMP_K) * d;
      default:    s = CNT_W'(1);
    endcase
    return s;
  endfunction

  function automatic logic pin_is(input logic [7:0] reg_val, input int idx,
                                  input logic [3:0] fn);
    return reg_val[idx*4 +: 4] == fn;
  endfunction

  // ==========================================================================
  // Registers
  logic [7:0]        pin_function_select_b, next_pin_function_select_b;
  logic [7:0]        pin_function_select_c, next_pin_function_select_c;
  logic [7:0]        filter_configuration, next_filter_configuration;
  logic [CNT_W-1:0]  strobe_count, next_strobe_count;
  logic [CNT_W-1:0]  phase_count, next_phase_count;
  logic              settled, next_settled;
  logic [DATA_W+10:0] acc, next_acc;
  logic [DATA_W-1:0] out_word, next_out_word;
  logic              frame, next_frame;
  logic [1:0]        ready_n, next_ready_n;
  logic [1:0]        oe, next_oe;
  logic [1:0]        path;
  logic [3:0]        dec_code;
  logic [CNT_W-1:0]  ratio;
  logic              cfg_write;
  logic              sync_low;
  logic              filter_clear;
  logic              emit;
  logic [3:0]        shift;
  logic [7:0]        pin_reg [2];

  assign path      = filter_configuration[PATH_LSB +: 2];
  assign dec_code  = filter_configuration[DEC_LSB +: 4];
  assign ratio     = ratio_of(path, dec_code);
  assign pin_reg[0] = pin_function_select_b;
  assign pin_reg[1] = pin_function_select_c;
  assign cfg_write = link.cfg_wr && (link.cfg_addr == FILTER_CONFIGURATION_OFFSET);

  // sync input on any pin set to sync
  always_comb begin
    sync_low = 1'b0;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 2; i++) begin
        if (pin_is(pin_reg[r], i, PIN_FN_SYNC) && !link.pin_from_host[i]) begin
          sync_low = 1'b1;
        end
      end
    end
  end

  assign filter_clear = cfg_write || sync_low;

  always_comb begin
    next_pin_function_select_b = pin_function_select_b;
    next_pin_function_select_c = pin_function_select_c;
    next_filter_configuration  = filter_configuration;
    if (link.cfg_wr) begin
      unique case (link.cfg_addr)
        PIN_FUNCTION_SELECT_B_OFFSET: next_pin_function_select_b = link.cfg_wdata;
        PIN_FUNCTION_SELECT_C_OFFSET: next_pin_function_select_c = link.cfg_wdata;
        FILTER_CONFIGURATION_OFFSET:  next_filter_configuration  = link.cfg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Filter sequencing
  always_comb begin
    next_strobe_count = strobe_count;
    next_phase_count  = phase_count;
    next_settled      = settled;
    next_acc          = acc;
    next_out_word     = out_word;
    next_frame        = 1'b0;
    emit              = 1'b0;
    shift             = '0;
    unique case (path)
      PATH_COMP: shift = dec_code + 4'h2;
      PATH_BYPASS: shift = '0;
      default:   shift = dec_code + 4'h1;
    endcase
    if (filter_clear) begin
      next_strobe_count = '0;
      next_phase_count  = '0;
      next_settled      = 1'b0;
      next_acc          = '0;
    end else if (link.convert_strobe) begin
      // frame repeats held word each conversion
      next_frame = 1'b1;
      if (path == PATH_BYPASS) begin
        emit          = 1'b1;
        next_settled  = 1'b1;
        next_out_word = link.sample;
      end else begin
        // Boxcar average stands in for every filter path; coefficients are not modeled
        if (!settled) begin
          next_strobe_count = strobe_count + CNT_W'(1);
        end
        if (phase_count == ratio - CNT_W'(1)) begin
          next_phase_count = '0;
          next_acc         = '0;
          if (settled || (strobe_count + CNT_W'(1) >= settle_of(path, ratio))) begin
            emit          = 1'b1;
            next_settled  = 1'b1;
            next_out_word = DATA_W'((acc + (DATA_W+11)'(link.sample)) >> shift);
          end
        end else begin
          next_phase_count = phase_count + CNT_W'(1);
          next_acc         = acc + (DATA_W+11)'(link.sample);
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_oe[i]      = pin_is(next_pin_function_select_b, i, PIN_FN_READY) ||
                        pin_is(next_pin_function_select_c, i, PIN_FN_READY);
      next_ready_n[i] = !(emit && next_oe[i]);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_function_select_b <= PIN_FUNCTION_RESET;
      pin_function_select_c <= PIN_FUNCTION_RESET;
      filter_configuration  <= FILTER_CONFIGURATION_RESET;
      strobe_count          <= '0;
      phase_count           <= '0;
      settled               <= 1'b0;
      acc                   <= '0;
      out_word              <= '0;
      frame                 <= 1'b0;
      ready_n               <= 2'h3;
      oe                    <= 2'h0;
    end else begin
      pin_function_select_b <= next_pin_function_select_b;
      pin_function_select_c <= next_pin_function_select_c;
      filter_configuration  <= next_filter_configuration;
      strobe_count          <= next_strobe_count;
      phase_count           <= next_phase_count;
      settled               <= next_settled;
      acc                   <= next_acc;
      out_word              <= next_out_word;
      frame                 <= next_frame;
      ready_n               <= next_ready_n;
      oe                    <= next_oe;
    end
  end

  // results stream only on the LVDS word
  assign link.lvds_word        = out_word;
  assign link.lvds_frame       = frame;
  assign link.pin_to_host      = ready_n;
  assign link.pin_oe           = oe;
  assign filter_configuration_out = filter_configuration;
  assign settled_out           = settled;
endmodule

// ### src/sinc_host_ctrl.sv
// Host end: issues strobes and config writes, syncs the filter, captures results.
// Assumes software drives the plain register port on the same clock.
`timescale 1ns/100ps
module sinc_host_ctrl
  import sinc_ctrl_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire logic [3:0]        addr_in,
  input  wire logic [15:0]       wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic [31:0]            rdata_out,
  output logic                   irq_out,
  sinc_link_if.host              link
);
  // ==========================================================================
  // Registers
  logic [31:0]          rdata, next_rdata;
  logic                 strobe, next_strobe;
  logic                 cwr, next_cwr;
  logic [7:0]           caddr, next_caddr;
  logic [7:0]           cdata, next_cdata;
  logic [1:0]           sync_n, next_sync_n;
  logic [1:0]           sync_left, next_sync_left;
  logic [1:0]           ready_pin, next_ready_pin;
  logic [DATA_W-1:0]    result, next_result;
  logic [DATA_W-1:0]    last_word, next_last_word;
  logic [15:0]          repeat_cnt, next_repeat_cnt;
  logic [HOST_ST_W-1:0] status, next_status;
  logic [HOST_ST_W-1:0] mask, next_mask;
  logic [HOST_ST_W-1:0] events;
  logic                 irq, next_irq;
  logic                 ready_fall;

  // results timed from ready pin, pin 0
  assign ready_fall = ready_pin[0] && !link.pin_to_host[0] && link.pin_oe[0];

  always_comb begin
    next_strobe     = 1'b0;
    next_cwr        = 1'b0;
    next_caddr      = caddr;
    next_cdata      = cdata;
    next_sync_n     = sync_n;
    next_sync_left  = sync_left;
    next_ready_pin  = link.pin_to_host;
    next_result     = result;
    next_last_word  = last_word;
    next_repeat_cnt = repeat_cnt;
    next_mask       = mask;
    next_rdata      = '0;
    events          = '0;
    if (wr_in) begin
      unique case (addr_in)
        // Bit 0 fires one convert strobe; bit 1 starts a sync
        HOST_CTRL_ADDR: begin
          next_strobe = wdata_in[0];
          if (wdata_in[1]) begin
            next_sync_n    = 2'h0;
            next_sync_left = 2'(SYNC_HOLD_STROBES);
          end
        end
        HOST_CFG_ADDR: begin
          next_cwr   = 1'b1;
          next_caddr = wdata_in[15:8];
          next_cdata = wdata_in[7:0];
        end
        HOST_MASK_ADDR: next_mask = wdata_in[HOST_ST_W-1:0];
        default: ;
      endcase
    end
    if (strobe && sync_n != 2'h3) begin
      if (sync_left <= 2'h1) begin
        next_sync_n   = 2'h3;
        next_sync_left = '0;
        events[ST_SYNCED] = 1'b1;
      end else begin
        next_sync_left = sync_left - 2'h1;
      end
    end
    if (link.lvds_frame) begin
      if (ready_fall) begin
        next_result = link.lvds_word;
        events[ST_RESULT] = 1'b1;
      end else if (link.lvds_word == last_word) begin
        next_repeat_cnt = repeat_cnt + 16'h1;
        events[ST_REPEAT] = 1'b1;
      end
      next_last_word = link.lvds_word;
    end
    // Set wins over write-one clear
    next_status = events | (status & ~((wr_in && addr_in == HOST_STATUS_ADDR) ?
                                       wdata_in[HOST_ST_W-1:0] : '0));
    next_irq = |(next_status & next_mask);
    if (rd_in) begin
      unique case (addr_in)
        HOST_DATA_ADDR:   next_rdata = 32'(result);
        HOST_STATUS_ADDR: next_rdata = 32'(status);
        HOST_MASK_ADDR:   next_rdata = 32'(mask);
        HOST_REPEAT_ADDR: next_rdata = 32'(repeat_cnt);
        HOST_CFG_ADDR:    next_rdata = {16'h0, caddr, cdata};
        default:          next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata      <= '0;
      strobe     <= 1'b0;
      cwr        <= 1'b0;
      caddr      <= '0;
      cdata      <= '0;
      sync_n     <= 2'h3;
      sync_left  <= '0;
      ready_pin  <= 2'h3;
      result     <= '0;
      last_word  <= '0;
      repeat_cnt <= '0;
      status     <= '0;
      mask       <= '0;
      irq        <= 1'b0;
    end else begin
      rdata      <= next_rdata;
      strobe     <= next_strobe;
      cwr        <= next_cwr;
      caddr      <= next_caddr;
      cdata      <= next_cdata;
      sync_n     <= next_sync_n;
      sync_left  <= next_sync_left;
      ready_pin  <= next_ready_pin;
      result     <= next_result;
      last_word  <= next_last_word;
      repeat_cnt <= next_repeat_cnt;
      status     <= next_status;
      mask       <= next_mask;
      irq        <= next_irq;
    end
  end

  assign rdata_out           = rdata;
  assign irq_out             = irq;
  assign link.convert_strobe = strobe;
  assign link.cfg_wr         = cwr;
  assign link.cfg_addr       = caddr;
  assign link.cfg_wdata      = cdata;
  assign link.pin_from_host  = sync_n;
endmodule

// ### test/sinc_link_properties.sv
// Concurrent checks on the link between the filter control and its host end.
// Assumes it sits beside the link interface, on the shared clock and reset.
`timescale 1ns/100ps
module sinc_link_properties
  import sinc_ctrl_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              convert_strobe,
  input  wire logic              cfg_wr,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [7:0]        cfg_wdata,
  input  wire logic [1:0]        pin_from_host,
  input  wire logic [1:0]        pin_to_host,
  input  wire logic [1:0]        pin_oe,
  input  wire logic [DATA_W-1:0] lvds_word,
  input  wire logic              lvds_frame
);
  // ==========================================================================
  // Shadow configuration and counters
  path_e            path,        next_path;
  logic [3:0]       dec,         next_dec;
  logic [3:0]       ready_fn,    next_ready_fn;
  logic [CNT_W-1:0] gap,         next_gap;
  logic [CNT_W-1:0] low_strobes, next_low_strobes;

  function automatic int ratio(path_e p, logic [3:0] c);
    return (p == PATH_COMP ? 4 : 2) << c;
  endfunction

  always_comb begin
    next_path = path;
    next_dec = dec;
    next_ready_fn = ready_fn;
    if (cfg_wr && cfg_addr == FILTER_CONFIGURATION_OFFSET) begin
      next_path = path_e'(cfg_wdata[PATH_LSB +: 2]);
      next_dec = cfg_wdata[DEC_LSB +: 4];
    end
    if (cfg_wr && cfg_addr == PIN_FUNCTION_SELECT_B_OFFSET) begin
      next_ready_fn = cfg_wdata[3:0];
    end
    // Gap counts frames without a ready pulse since the last one
    next_gap = gap;
    if (lvds_frame) begin
      next_gap = !pin_to_host[0] ? '0 : gap + 1'b1;
    end
    next_low_strobes = (&pin_from_host) ? '0 : low_strobes + CNT_W'(convert_strobe);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      path <= PATH_BYPASS;
      dec <= 4'h0;
      ready_fn <= PIN_FUNCTION_RESET[3:0];
      gap <= '0;
      low_strobes <= '0;
    end else begin
      path <= next_path;
      dec <= next_dec;
      ready_fn <= next_ready_fn;
      gap <= next_gap;
      low_strobes <= next_low_strobes;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence emit_s;
    lvds_frame && !pin_to_host[0];
  endsequence
  sequence sync_release_s;
    $rose(&pin_from_host);
  endsequence

  ready_one_cycle_a: assert property ($fell(pin_to_host[0]) |=> pin_to_host[0])
    else $error("ready pin low for more than one cycle");
  ready_after_strobe_a: assert property (!pin_to_host[0] |-> $past(convert_strobe))
    else $error("ready pulse without a preceding convert strobe");
  frame_after_strobe_a: assert property (lvds_frame |-> $past(convert_strobe))
    else $error("output frame without a preceding convert strobe");
  word_hold_a: assert property ($changed(lvds_word) |-> emit_s)
    else $error("output word changed without a new result");
  ready_pin_enable_a: assert property (cfg_wr && cfg_addr == PIN_FUNCTION_SELECT_B_OFFSET
    |-> ##2 pin_oe == {$past(cfg_wdata[7:4], 2) == PIN_FN_READY,
                       $past(cfg_wdata[3:0], 2) == PIN_FN_READY})
    else $error("pin enable does not follow pin function");
  ratio_spacing_a: assert property ((emit_s and path != PATH_BYPASS)
    |-> gap >= CNT_W'(ratio(path, dec) - 1))
    else $error("results closer than the decimation ratio");
  bypass_every_a: assert property (convert_strobe && path == PATH_BYPASS && !cfg_wr
    && ready_fn == PIN_FN_READY && (&pin_from_host) |=> emit_s)
    else $error("bypass did not emit on every strobe");
  sync_hold_a: assert property (sync_release_s |-> low_strobes >= 1)
    else $error("sync released before a full conversion");
endmodule

// ### test/tb_decimating_sinc_filter_control.sv
// Bench for the filter control joined to its host end over the link interface.
// Assumes the host register map and link timing shared by the two ends.
`timescale 1ns/100ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_decimating_sinc_filter_control;
  import sinc_ctrl_pkg::*;
  localparam logic [DATA_W-1:0] SAMPLE_VAL = 20'h5A3C1;
  logic              clk_in, arst_n_in, wr_in, rd_in, irq_out, settled;
  logic [3:0]        addr_in;
  logic [15:0]       wdata_in;
  logic [31:0]       rdata_out, rd_val;
  logic [7:0]        filter_cfg;
  logic [DATA_W-1:0] w;
  int                num_errors, cmp_count, ready_cnt, frame_cnt, d, settle, r;

  sinc_link_if sinc_link_if_inst ();
  sinc_filter_ctrl sinc_filter_ctrl_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .link(sinc_link_if_inst), .filter_configuration_out(filter_cfg), .settled_out(settled));
  sinc_host_ctrl sinc_host_ctrl_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .link(sinc_link_if_inst));
  sinc_link_properties sinc_link_properties_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .convert_strobe(sinc_link_if_inst.convert_strobe), .cfg_wr(sinc_link_if_inst.cfg_wr),
    .cfg_addr(sinc_link_if_inst.cfg_addr), .cfg_wdata(sinc_link_if_inst.cfg_wdata),
    .pin_from_host(sinc_link_if_inst.pin_from_host),
    .pin_to_host(sinc_link_if_inst.pin_to_host), .pin_oe(sinc_link_if_inst.pin_oe),
    .lvds_word(sinc_link_if_inst.lvds_word), .lvds_frame(sinc_link_if_inst.lvds_frame));

  always #25 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    if (sinc_link_if_inst.lvds_frame === 1'b1) frame_cnt++;
    if (sinc_link_if_inst.pin_to_host[0] === 1'b0) ready_cnt++;
  end

  // ==========================================================================
  // Register port and link tasks
  task automatic host_wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= dat;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic host_rd(input logic [3:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rd_val = rdata_out;
  endtask

  task automatic cfg(input logic [7:0] a, input logic [7:0] dat);
    host_wr(HOST_CFG_ADDR, {a, dat});
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // Strobe lands one cycle after the write, its frame two cycles later
  task automatic strobe(input int n);
    repeat (n) begin
      host_wr(HOST_CTRL_ADDR, 16'h0001);
      repeat (3) @(posedge clk_in);
      #1;
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    num_errors++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    clk_in = 1'b0;
    arst_n_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 16'h0000;
    rd_val = 32'h00000000;
    sinc_link_if_inst.sample = SAMPLE_VAL;
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    #1 `CHECK(filter_cfg, FILTER_CONFIGURATION_RESET)
    host_rd(HOST_STATUS_ADDR);
    `CHECK(rd_val, 32'h00000000)
    host_rd(4'hF);
    `CHECK(rd_val, 32'h00000000)
    cfg(PIN_FUNCTION_SELECT_B_OFFSET, {PIN_FN_SYNC, PIN_FN_READY});
    `CHECK(sinc_link_if_inst.pin_oe, 2'b01)
    // Second pin register can carry the ready function as well
    cfg(PIN_FUNCTION_SELECT_C_OFFSET, {PIN_FN_READY, 4'h0});
    `CHECK(sinc_link_if_inst.pin_oe, 2'b11)
    cfg(PIN_FUNCTION_SELECT_C_OFFSET, 8'h00);
    `CHECK(sinc_link_if_inst.pin_oe, 2'b01)
    // Bypass result, status, mask and clear
    strobe(1);
    host_rd(HOST_DATA_ADDR);
    `CHECK(rd_val[DATA_W-1:0], SAMPLE_VAL)
    host_rd(HOST_STATUS_ADDR);
    `CHECK(rd_val[ST_RESULT], 1'b1)
    host_wr(HOST_MASK_ADDR, 16'h0001);
    repeat (2) @(posedge clk_in);
    #1 `CHECK(irq_out, 1'b1)
    host_wr(HOST_STATUS_ADDR, 16'h0007);
    repeat (2) @(posedge clk_in);
    #1 `CHECK(irq_out, 1'b0)
    host_wr(HOST_MASK_ADDR, 16'h0000);
    strobe(1);
    `CHECK(irq_out, 1'b0)
    host_wr(HOST_STATUS_ADDR, 16'h0007);
    // Settling count of every filter path at code 0
    for (int p = 1; p <= 3; p++) begin
      d = (p == 3) ? 4 : 2;
      settle = SETTLE_BASE + ((p == 1) ? SINC1_K * d + SINC1_C :
               (p == 2) ? SINC5_K * d + SINC5_C : COMP_K * d + COMP_C);
      cfg(FILTER_CONFIGURATION_OFFSET, {6'h00, 2'(p)});
      `CHECK(filter_cfg, {6'h00, 2'(p)})
      strobe(settle - 1);
      `CHECK(settled, 1'b0)
      strobe(d);
      `CHECK(settled, 1'b1)
      `CHECK(sinc_link_if_inst.lvds_word, SAMPLE_VAL)
    end
    // First order, code 2 gives ratio 8: count results, held word repeats
    settle = SETTLE_BASE + SINC1_K * 8 + SINC1_C;
    cfg(FILTER_CONFIGURATION_OFFSET, 8'h21);
    strobe(settle + 8);
    ready_cnt = 0;
    frame_cnt = 0;
    for (int i = 0; i < 32; i++) begin
      w = sinc_link_if_inst.lvds_word;
      r = ready_cnt;
      // Rising samples so that a new result always differs from the held one
      @(posedge clk_in);
      sinc_link_if_inst.sample <= SAMPLE_VAL + DATA_W'(i);
      strobe(1);
      if (ready_cnt == r) `CHECK(sinc_link_if_inst.lvds_word, w)
      else `CHECK(sinc_link_if_inst.lvds_word !== w, 1'b1)
    end
    `CHECK(ready_cnt, 4)
    `CHECK(frame_cnt, 32)
    // Sync pin clears the filter
    host_wr(HOST_CTRL_ADDR, 16'h0002);
    strobe(2);
    for (int i = 0; i < 20 && rd_val[ST_SYNCED] !== 1'b1; i++) host_rd(HOST_STATUS_ADDR);
    `CHECK(rd_val[ST_SYNCED], 1'b1)
    if (rd_val[ST_SYNCED] !== 1'b1) stop_test();
    `CHECK(settled, 1'b0)
    // Rewriting the same configuration still clears the filter
    strobe(settle + 8);
    `CHECK(settled, 1'b1)
    cfg(FILTER_CONFIGURATION_OFFSET, 8'h21);
    `CHECK(settled, 1'b0)
    stop_test();
  end
endmodule
